// File: rtl/sstat_defines.svh
// Offsets, field positions, reset values and counts of the status block
`ifndef SSTAT_DEFINES_SVH
`define SSTAT_DEFINES_SVH

`define SSTAT_ADDR_W        4
`define SSTAT_OFS_STATUS    4'h0
`define SSTAT_OFS_CONTROL   4'h4
`define SSTAT_OFS_EVT       4'h8
`define SSTAT_OFS_MASK      4'hC

`define SSTAT_RXCNT_MSB     28
`define SSTAT_RXCNT_LSB     24
`define SSTAT_TXCNT_MSB     20
`define SSTAT_TXCNT_LSB     16
`define SSTAT_FRAMING_FAULT_FLAG_BIT    12
`define SSTAT_BUSY_BIT      11
`define SSTAT_TUR_BIT       8
`define SSTAT_SHIFTER_EMPTY_FLAG_BIT      7
`define SSTAT_ROV_BIT       6
`define SSTAT_RBE_BIT       5
`define SSTAT_TBE_BIT       3
`define SSTAT_TBF_BIT       1
`define SSTAT_RBF_BIT       0

`define SSTAT_CTL_ON_BIT    0
`define SSTAT_CTL_ENH_BIT   1
`define SSTAT_CTL_FRM_BIT   2

`define SSTAT_EVT_W         3
`define SSTAT_EVT_FRM       0
`define SSTAT_EVT_TUR       1
`define SSTAT_EVT_ROV       2
`define SSTAT_EVT_RST       3'h0
`define SSTAT_MASK_RST      3'h0
`define SSTAT_CTL_RST       3'h0

`define SSTAT_PTR_W         4
`define SSTAT_CNT_W         5
`define SSTAT_DATA_W        32

`endif

// File: rtl/sstat_flag.sv
// Sticky flag: hardware set wins over a same-cycle clear
`timescale 1ns/1ps
module sstat_flag (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic set_in,
	input  wire logic clr_in,
	output logic      flag_ff
);
	// Set has priority over clear
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flag_ff <= 1'b0;
		end else if (set_in) begin
			flag_ff <= 1'b1;
		end else if (clr_in) begin
			flag_ff <= 1'b0;
		end
	end
endmodule

// File: rtl/sstat_pkg.sv
// Types shared by the status block
package sstat_pkg;

	// Events raised by the serial unit, one-cycle pulses
	typedef struct packed {
		logic frame_err;
		logic underrun;
		logic word_done;
	} sstat_evt_t;

	// Levels that describe the buffers and the shifter
	typedef struct packed {
		logic [3:0] fifo_read_pointer;
		logic [3:0] fifo_write_pointer;
		logic [4:0] rx_count;
		logic [4:0] tx_count;
		logic       shifter_empty;
		logic       tx_empty;
		logic       tx_full;
		logic       transfer_active;
	} sstat_lvl_t;

	typedef enum logic [1:0] {
		SSTAT_IDLE = 2'h0,
		SSTAT_SHIFT = 2'h1,
		SSTAT_DONE = 2'h3
	} sstat_state_t;

endpackage

// File: rtl/sstat_sync.sv
// Two-stage synchroniser for one level
`timescale 1ns/1ps
module sstat_sync (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_ff;

	// First stage feeds only the second
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= 1'b0;
			q_out   <= 1'b0;
		end else begin
			meta_ff <= d_in;
			q_out   <= meta_ff;
		end
	end
endmodule

// File: rtl/sstat_top.sv
// Status register, event capture and interrupt of the serial unit
// Function
// - Receive entry count is reported in bits 28-24 while deep buffering is on.
// - Transmit entry count is reported in bits 20-16 while deep buffering is on.
// - A framing fault sets bit 12, meaningful only in framed mode.
// - Bit 11 is high while a transfer is in progress and low when idle.
// - Transmit underrun in framed mode sets bit 8, cleared only by turning the unit off.
// - Bit 7 shows an empty shifter, meaningful only while deep buffering is on.
// - A word completing while the previous is unread is dropped and sets bit 6.
// - Only hardware sets the overflow bit; a software write of zero clears it.
// - Bit 5 is set when deep buffering is on and the FIFO read and write pointers are equal.
// - Unimplemented bits 31-29, 23-21, 15-13, 10-9 and 4 read as zero.
`timescale 1ns/1ps
`include "sstat_defines.svh"
module sstat_top (
	input  wire logic                       clk_sys,
	input  wire logic                       rst_b,
	input  wire logic [`SSTAT_ADDR_W-1:0]   bus_addr,
	input  wire logic [`SSTAT_DATA_W-1:0]   bus_wdata,
	input  wire logic                       bus_wr,
	input  wire logic                       bus_rd,
	output logic      [`SSTAT_DATA_W-1:0]   bus_rdata_ff,
	input  wire sstat_pkg::sstat_evt_t      unit_evt,
	input  wire sstat_pkg::sstat_lvl_t      unit_lvl,
	input  wire logic                       rx_word_read,
	input  wire logic                       frame_pin,
	output logic [`SSTAT_DATA_W-1:0]        rx_data_ff,
	input  wire logic [`SSTAT_DATA_W-1:0]   rx_word,
	output logic                            drop_word_ff,
	output logic                            unit_on_ff,
	output logic                            deep_buffer_enable_ff,
	output logic                            framed_mode_enable_ff,
	output logic                            irq_ff
);

	// Control register bits
	logic [2:0]                 ctl_ff;
	logic [2:0]                 nxt_ctl;
	logic [`SSTAT_EVT_W-1:0]    mask_ff;
	logic [`SSTAT_EVT_W-1:0]    evt_st_ff;
	logic                       rbf_ff;
	logic                       frm_sync;
	logic                       frm_prev_ff;
	logic                       framing_fault_flag;
	logic                       tx_underrun_flag;
	logic                       rx_overflow_flag;
	logic                       busy_ff;
	logic [`SSTAT_PTR_W-1:0]    rptr_ff;
	logic [`SSTAT_PTR_W-1:0]    wptr_ff;
	logic [`SSTAT_CNT_W-1:0]    rxcnt_ff;
	logic [`SSTAT_CNT_W-1:0]    txcnt_ff;
	logic                       shifter_empty_flag_ff;
	logic                       tbe_ff;
	logic                       tbf_ff;
	logic                       prev_on_ff;
	sstat_pkg::sstat_state_t    state_ff;
	sstat_pkg::sstat_state_t    nxt_state;

	// Address decode
	wire sel_status  = (bus_addr == `SSTAT_OFS_STATUS);
	wire sel_control = (bus_addr == `SSTAT_OFS_CONTROL);
	wire sel_evt     = (bus_addr == `SSTAT_OFS_EVT);
	wire sel_mask    = (bus_addr == `SSTAT_OFS_MASK);
	wire wr_status   = bus_wr & sel_status;
	wire wr_control  = bus_wr & sel_control;
	wire wr_evt      = bus_wr & sel_evt;
	wire wr_mask     = bus_wr & sel_mask;

	wire unit_on  = ctl_ff[`SSTAT_CTL_ON_BIT];
	wire deep_on  = ctl_ff[`SSTAT_CTL_ENH_BIT];
	wire framed   = ctl_ff[`SSTAT_CTL_FRM_BIT];

	// Frame pin from outside, synchronised before use
	sstat_sync u_frm_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.d_in    (frame_pin),
		.q_out   (frm_sync)
	);

	// Frame pin pulse while busy counts as a framing fault
	wire frm_edge    = frm_sync & ~frm_prev_ff;
	wire frm_err_set = framed & unit_on &
		(unit_evt.frame_err | (frm_edge & busy_ff));

	// Underrun only counts in framed mode
	wire tur_set = framed & unit_on & unit_evt.underrun;
	// Turning the unit off clears the underrun
	wire tur_clr = prev_on_ff & ~unit_on;

	// Word arrives while previous unread: drop and flag
	wire ovf_set = unit_on & unit_evt.word_done & rbf_ff &
		~rx_word_read;
	wire word_keep = unit_on & unit_evt.word_done & ~ovf_set;

	// Software write of zero to bit 6 clears overflow
	wire rov_clr = wr_status & ~bus_wdata[`SSTAT_ROV_BIT];
	// Frame error is clearable the same way
	wire frm_clr = wr_status & ~bus_wdata[`SSTAT_FRAMING_FAULT_FLAG_BIT];

	sstat_flag u_frm_flag (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.set_in  (frm_err_set),
		.clr_in  (frm_clr),
		.flag_ff (framing_fault_flag)
	);

	sstat_flag u_tur_flag (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.set_in  (tur_set),
		.clr_in  (tur_clr),
		.flag_ff (tx_underrun_flag)
	);

	sstat_flag u_rov_flag (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.set_in  (ovf_set),
		.clr_in  (rov_clr),
		.flag_ff (rx_overflow_flag)
	);

	// Fields held at zero outside deep buffer mode
	wire [`SSTAT_CNT_W-1:0] rx_cnt_q = deep_on ? rxcnt_ff :
		`SSTAT_CNT_W'(0);
	wire [`SSTAT_CNT_W-1:0] tx_cnt_q = deep_on ? txcnt_ff :
		`SSTAT_CNT_W'(0);
	wire shifter_empty_flag_q = deep_on & shifter_empty_flag_ff;
	wire rbe_q  = deep_on & (rptr_ff == wptr_ff);

	// Status word assembly, unimplemented bits zero
	logic [`SSTAT_DATA_W-1:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[`SSTAT_RXCNT_MSB:`SSTAT_RXCNT_LSB] = rx_cnt_q;
		status_word[`SSTAT_TXCNT_MSB:`SSTAT_TXCNT_LSB] = tx_cnt_q;
		status_word[`SSTAT_FRAMING_FAULT_FLAG_BIT] = framing_fault_flag;
		status_word[`SSTAT_BUSY_BIT]   = busy_ff;
		status_word[`SSTAT_TUR_BIT]    = tx_underrun_flag;
		status_word[`SSTAT_SHIFTER_EMPTY_FLAG_BIT]   = shifter_empty_flag_q;
		status_word[`SSTAT_ROV_BIT]    = rx_overflow_flag;
		status_word[`SSTAT_RBE_BIT]    = rbe_q;
		status_word[`SSTAT_TBE_BIT]    = tbe_ff;
		status_word[`SSTAT_TBF_BIT]    = tbf_ff;
		status_word[`SSTAT_RBF_BIT]    = rbf_ff;
	end

	// Read data mux, unmapped reads return zero
	wire [`SSTAT_DATA_W-1:0] rd_mux =
		sel_status  ? status_word :
		sel_control ? {29'h0, ctl_ff} :
		sel_evt     ? {29'h0, evt_st_ff} :
		sel_mask    ? {29'h0, mask_ff} : 32'h0;

	// Read data valid in the cycle after the strobe only
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			bus_rdata_ff <= 32'h0;
		end else begin
			bus_rdata_ff <= bus_rd ? rd_mux : 32'h0;
		end
	end

	// Control and mask register update
	assign nxt_ctl = wr_control ? bus_wdata[2:0] : ctl_ff;
	wire [`SSTAT_EVT_W-1:0] nxt_mask = wr_mask ?
		bus_wdata[`SSTAT_EVT_W-1:0] : mask_ff;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctl_ff     <= `SSTAT_CTL_RST;
			prev_on_ff <= 1'b0;
			mask_ff    <= `SSTAT_MASK_RST;
		end else begin
			ctl_ff     <= nxt_ctl;
			prev_on_ff <= unit_on;
			mask_ff    <= nxt_mask;
		end
	end

	// Interrupt events: sticky, write one clears, set wins
	wire [`SSTAT_EVT_W-1:0] evt_set = {ovf_set, tur_set, frm_err_set};
	wire [`SSTAT_EVT_W-1:0] evt_clr = wr_evt ?
		bus_wdata[`SSTAT_EVT_W-1:0] : `SSTAT_EVT_RST;
	wire [`SSTAT_EVT_W-1:0] nxt_evt_st = evt_set | (evt_st_ff & ~evt_clr);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			evt_st_ff <= `SSTAT_EVT_RST;
			irq_ff    <= 1'b0;
		end else begin
			evt_st_ff <= nxt_evt_st;
			irq_ff    <= |(nxt_evt_st & nxt_mask);
		end
	end

	// Receive holding buffer: full until software reads it or the unit is turned off
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rbf_ff       <= 1'b0;
			rx_data_ff   <= 32'h0;
			drop_word_ff <= 1'b0;
		end else begin
			drop_word_ff <= ovf_set;
			if (!unit_on) begin
				rbf_ff <= 1'b0;
			end else if (word_keep) begin
				rbf_ff     <= 1'b1;
				rx_data_ff <= rx_word;
			end else if (rx_word_read) begin
				rbf_ff <= 1'b0;
			end
		end
	end

	// Activity state machine tracks transfers in progress
	always_comb begin
		case (state_ff)
			sstat_pkg::SSTAT_IDLE:
				nxt_state = (unit_on & unit_lvl.transfer_active) ?
					sstat_pkg::SSTAT_SHIFT : sstat_pkg::SSTAT_IDLE;
			sstat_pkg::SSTAT_SHIFT:
				nxt_state = (!unit_on | !unit_lvl.transfer_active) ?
					sstat_pkg::SSTAT_DONE : sstat_pkg::SSTAT_SHIFT;
			sstat_pkg::SSTAT_DONE:
				nxt_state = sstat_pkg::SSTAT_IDLE;
			default:
				nxt_state = sstat_pkg::SSTAT_IDLE;
		endcase
	end

	// Busy follows transfer activity of the unit
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= sstat_pkg::SSTAT_IDLE;
			busy_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			busy_ff  <= unit_on & unit_lvl.transfer_active;
		end
	end

	// Snapshot of buffer levels and pointers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rptr_ff     <= 4'h0;
			wptr_ff     <= 4'h0;
			rxcnt_ff    <= 5'h00;
			txcnt_ff    <= 5'h00;
			shifter_empty_flag_ff     <= 1'b1;
			tbe_ff      <= 1'b1;
			tbf_ff      <= 1'b0;
			frm_prev_ff <= 1'b0;
		end else begin
			rptr_ff     <= unit_lvl.fifo_read_pointer;
			wptr_ff     <= unit_lvl.fifo_write_pointer;
			rxcnt_ff    <= unit_lvl.rx_count;
			txcnt_ff    <= unit_lvl.tx_count;
			shifter_empty_flag_ff     <= unit_lvl.shifter_empty;
			tbe_ff      <= unit_lvl.tx_empty;
			tbf_ff      <= unit_lvl.tx_full;
			frm_prev_ff <= frm_sync;
		end
	end

	// Mode outputs to the rest of the unit
	assign unit_on_ff            = ctl_ff[`SSTAT_CTL_ON_BIT];
	assign deep_buffer_enable_ff = ctl_ff[`SSTAT_CTL_ENH_BIT];
	assign framed_mode_enable_ff = ctl_ff[`SSTAT_CTL_FRM_BIT];

	// Overflow flag sets one cycle after a dropped word
	ovf_sets_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		ovf_set |=> rx_overflow_flag)
		else $error("overflow flag not set after dropped word");

	// Overflow holds unless a zero is written
	ovf_holds_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		rx_overflow_flag & ~rov_clr |=> rx_overflow_flag)
		else $error("overflow flag dropped without clear");

	// Set wins over a same-cycle clear
	set_wins_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		ovf_set & rov_clr |=> rx_overflow_flag)
		else $error("clear beat hardware set");

	// Underrun survives until the unit is turned off
	tur_holds_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		tx_underrun_flag & unit_on |=> tx_underrun_flag)
		else $error("underrun cleared while unit on");

	// Framing fault only in framed mode
	frm_gate_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(framing_fault_flag) |-> $past(framed))
		else $error("frame error outside framed mode");

	// Busy follows activity with one cycle of delay
	busy_track_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		unit_on & unit_lvl.transfer_active ##1 1'b1 |-> busy_ff)
		else $error("busy not raised for a transfer");

	// Empty bit equals pointer match in deep mode
	rbe_match_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		deep_on |-> status_word[`SSTAT_RBE_BIT] == (rptr_ff == wptr_ff))
		else $error("rx empty does not match pointers");

	// Reserved bits of status read back zero
	resv_zero_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		bus_rd & sel_status |=> (bus_rdata_ff & 32'hE0E0E610) == 32'h0)
		else $error("reserved status bits not zero");

	// Counts, shifter and empty bits read zero outside deep mode
	cnt_gate_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		!deep_on |-> status_word[28:16] == 13'h0000 &&
		!status_word[`SSTAT_SHIFTER_EMPTY_FLAG_BIT] && !status_word[`SSTAT_RBE_BIT])
		else $error("levels visible outside deep mode");

	// Shift state only while busy is shown
	shift_busy_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		state_ff == sstat_pkg::SSTAT_SHIFT |-> busy_ff)
		else $error("shift state without busy");

	// Busy drops once the unit is off
	busy_idle_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		!unit_on |=> !busy_ff)
		else $error("busy while unit off");

	// Underrun rises only from a framed, enabled unit
	tur_framed_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(tx_underrun_flag) |-> $past(tur_set))
		else $error("underrun outside framed mode");

	// Overflow rises only from a hardware drop
	ovf_hw_only_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(rx_overflow_flag) |-> $past(ovf_set))
		else $error("overflow set without a drop");

	// Dropped word leaves the held word alone
	drop_keep_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		ovf_set |=> drop_word_ff && $stable(rx_data_ff) &&
		evt_st_ff[`SSTAT_EVT_ROV])
		else $error("dropped word not discarded");

	// Interrupt line follows unmasked event bits
	irq_level_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		irq_ff == |(evt_st_ff & mask_ff))
		else $error("interrupt does not match events");

endmodule

// File: verification/sstat_unit_model.sv
// Behavioural serial unit that feeds events and levels to the status block
`timescale 1ns/1ps
module sstat_unit_model (
	input  wire logic             clk_sys,
	output sstat_pkg::sstat_evt_t unit_evt,
	output sstat_pkg::sstat_lvl_t unit_lvl,
	output logic [31:0]           rx_word,
	output logic                  frame_pin
);
	// Idle: transmit side empty, shifter empty
	initial begin
		unit_evt = '0;
		unit_lvl = 22'h00000C;
		rx_word = 32'h0;
		frame_pin = 1'b0;
	end
	// New buffer levels just after an edge
	task automatic set_lvl(input sstat_pkg::sstat_lvl_t lv);
		@(posedge clk_sys);
		unit_lvl <= lv;
	endtask
	// Events last exactly one cycle
	task automatic pulse(input sstat_pkg::sstat_evt_t ev);
		@(posedge clk_sys);
		unit_evt <= ev;
		@(posedge clk_sys);
		unit_evt <= '0;
	endtask
	// Frame pin high for four cycles, then low again
	task automatic frame_pulse;
		@(posedge clk_sys);
		frame_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		frame_pin <= 1'b0;
	endtask
	// Shift a word in; data goes stale once the done pulse ends
	task automatic send_word(input logic [31:0] w);
		@(posedge clk_sys);
		unit_lvl.transfer_active <= 1'b1;
		repeat (3) @(posedge clk_sys);
		unit_lvl.transfer_active <= 1'b0;
		unit_evt.word_done <= 1'b1;
		rx_word <= w;
		@(posedge clk_sys);
		unit_evt.word_done <= 1'b0;
		rx_word <= ~w;
	endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the serial status block
`timescale 1ns/1ps
`include "sstat_defines.svh"
module testbench;
	logic                  clk_sys;
	logic                  rst_b;
	logic [3:0]            bus_addr;
	logic [31:0]           bus_wdata;
	logic                  bus_wr;
	logic                  bus_rd;
	logic [31:0]           bus_rdata_ff;
	sstat_pkg::sstat_evt_t unit_evt;
	sstat_pkg::sstat_lvl_t unit_lvl;
	logic                  rx_word_read;
	logic                  frame_pin;
	logic [31:0]           rx_data_ff;
	logic [31:0]           rx_word;
	logic                  drop_word_ff;
	logic [2:0]            ctl_out;
	logic                  irq_ff;
	int                    bad_count;
	int                    total_checks;
	int                    drops;
	localparam logic [3:0] st = `SSTAT_OFS_STATUS;
	localparam logic [3:0] ctl = `SSTAT_OFS_CONTROL;
	localparam logic [3:0] evr = `SSTAT_OFS_EVT;
	localparam logic [3:0] msk = `SSTAT_OFS_MASK;
	localparam logic [31:0] tbe = 32'h1 << `SSTAT_TBE_BIT;
	localparam logic [31:0] rbf = 32'h1 << `SSTAT_RBF_BIT;
	localparam logic [31:0] rov = 32'h1 << `SSTAT_ROV_BIT;
	localparam logic [31:0] tur = 32'h1 << `SSTAT_TUR_BIT;
	localparam logic [31:0] frm = 32'h1 << `SSTAT_FRAMING_FAULT_FLAG_BIT;
	localparam logic [31:0] bsy = 32'h1 << `SSTAT_BUSY_BIT;

	// 20 MHz clock
	initial clk_sys = 1'b0;
	always #25 clk_sys = ~clk_sys;

	sstat_top dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata_ff(bus_rdata_ff), .unit_evt(unit_evt),
		.unit_lvl(unit_lvl), .rx_word_read(rx_word_read),
		.frame_pin(frame_pin), .rx_data_ff(rx_data_ff),
		.rx_word(rx_word), .drop_word_ff(drop_word_ff),
		.unit_on_ff(ctl_out[0]), .deep_buffer_enable_ff(ctl_out[1]),
		.framed_mode_enable_ff(ctl_out[2]), .irq_ff(irq_ff)
	);
	sstat_unit_model u_unit (
		.clk_sys(clk_sys), .unit_evt(unit_evt), .unit_lvl(unit_lvl),
		.rx_word(rx_word), .frame_pin(frame_pin)
	);

	// Count discard pulses
	always @(posedge clk_sys) if (drop_word_ff === 1'b1) drops++;

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
	endtask
	// Read data is looked at in the one cycle it stands
	task automatic rd(input string s, input logic [3:0] a,
		input logic [31:0] exp);
		@(posedge clk_sys);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1;
		chk(s, exp, bus_rdata_ff);
	endtask
	task automatic chk_irq(input logic exp);
		repeat (2) @(negedge clk_sys);
		chk("irq", {31'h0, exp}, {31'h0, irq_ff});
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (5000) @(posedge clk_sys);
		bad_count++;
		wrap_up();
	end

	initial begin
		rst_b = 1'b0;
		bus_addr = 4'h0;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		rx_word_read = 1'b0;
		bad_count = 0;
		total_checks = 0;
		drops = 0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd("status", st, tbe);
		rd("events", evr, 32'h0);
		rd("unmapped", 4'h2, 32'h0);
		chk_irq(1'b0);
		$display("done reset");
		// Deep mode levels, then hidden outside it
		wr(ctl, 32'h3);
		#1;
		chk("ctl", 32'h3, {29'h0, ctl_out});
		u_unit.set_lvl({4'h3, 4'h3, 5'h1F, 5'h11, 4'hA});
		rd("levels", st, 32'h1F1100A2);
		u_unit.set_lvl({4'h2, 4'h3, 5'h01, 5'h10, 4'h4});
		rd("levels", st, 32'h01100008);
		wr(st, 32'hFFFFFFFF);
		rd("ro", st, 32'h01100008);
		wr(ctl, 32'h1);
		u_unit.set_lvl({4'h3, 4'h3, 5'h01, 5'h10, 4'hC});
		rd("hidden", st, tbe);
		u_unit.set_lvl({4'h2, 4'h3, 5'h01, 5'h10, 4'h5});
		rd("busy", st, bsy | tbe);
		wr(ctl, 32'h0);
		rd("idle", st, tbe);
		u_unit.set_lvl({4'h2, 4'h3, 5'h01, 5'h10, 4'h4});
		$display("done levels");
		// Overflow: second word dropped, flag sticky until written 0
		wr(msk, 32'h4);
		wr(ctl, 32'h1);
		u_unit.send_word(32'hA5A50001);
		u_unit.send_word(32'h5A5A0002);
		repeat (2) @(posedge clk_sys);
		chk("drops", 32'h1, drops);
		chk("held", 32'hA5A50001, rx_data_ff);
		rd("ovf", st, rov | rbf | tbe);
		rd("events", evr, 32'h4);
		chk_irq(1'b1);
		wr(st, 32'hFFFFFFFF);
		rd("ovf kept", st, rov | rbf | tbe);
		wr(st, 32'h0);
		rd("ovf clr", st, rbf | tbe);
		chk_irq(1'b1);
		wr(evr, 32'h4);
		chk_irq(1'b0);
		@(posedge clk_sys);
		rx_word_read <= 1'b1;
		@(posedge clk_sys);
		rx_word_read <= 1'b0;
		u_unit.send_word(32'h0000C3C3);
		repeat (2) @(posedge clk_sys);
		chk("held", 32'h0000C3C3, rx_data_ff);
		chk("drops", 32'h1, drops);
		$display("done overflow");
		// Underrun only in framed mode; cleared by off then on
		u_unit.pulse(3'h2);
		rd("no tur", st, rbf | tbe);
		wr(ctl, 32'h5);
		#1;
		chk("ctl", 32'h5, {29'h0, ctl_out});
		u_unit.pulse(3'h6);
		rd("tur frm", st, tur | frm | rbf | tbe);
		rd("events", evr, 32'h3);
		chk_irq(1'b0);
		wr(msk, 32'h2);
		chk_irq(1'b1);
		wr(st, 32'h0);
		rd("tur kept", st, tur | rbf | tbe);
		wr(ctl, 32'h4);
		wr(ctl, 32'h5);
		rd("tur clr", st, tbe);
		wr(evr, 32'h3);
		chk_irq(1'b0);
		$display("done underrun");
		// Frame pin edge counts as a fault only while busy
		u_unit.frame_pulse();
		rd("pin idle", st, tbe);
		u_unit.set_lvl({4'h2, 4'h3, 5'h01, 5'h10, 4'h5});
		u_unit.frame_pulse();
		rd("pin busy", st, frm | bsy | tbe);
		rd("events", evr, 32'h1);
		wr(st, 32'h0);
		rd("frm clr", st, bsy | tbe);
		$display("done frame pin");
		wrap_up();
	end
endmodule
